// ==== design/dcr_receiver.sv ====
`include "dcr_regs.svh"
`default_nettype none
// Notes on behaviour
// - Eight-lane core, four unused lanes output zero.
// - Two octets, sixteen frames, descrambling on.
// - Single core or two split cores.
// - Split cores: AND both SYNC requests.
// - SYNC launched on local multiframe edge.
// - Invert every lane after decoding.
// - Two transceiver groups, own reference each.
// - Core clock and SYSREF from first board.
// - 5.89824 Gbps lanes, 147.456 MHz user clocks.
// - 8B/10B decode, 32-bit word per lane.
// - Forward raw lane frames, no sample mapping.
module dcr_receiver #(
   parameter int LANES_CORE = `DCR_LANES_CORE,
   parameter int LANES_USED = `DCR_LANES_USED,
   parameter bit SPLIT_CORES = 1'b0,
   parameter int CGS_WORDS = `DCR_CGS_WORDS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sysrefPin,
   input var dcr_pkg::dcr_lane_t laneA0,
   input var dcr_pkg::dcr_lane_t laneA1,
   input var dcr_pkg::dcr_lane_t laneB0,
   input var dcr_pkg::dcr_lane_t laneB1,
   output logic syncA_n,
   output logic syncB_n,
   output var dcr_pkg::dcr_frame_t frameOut,
   output logic linkUp
);
   import dcr_pkg::*;
   // Lane clock figure kept for reference only; no count is derived from it.
   localparam int LANE_CLK_KHZ = `DCR_LANE_CLK_KHZ;
   localparam int CONV_LANES = `DCR_LANES_PER_CONV;

   dcr_lane_t lanesIn [LANES_USED];
   dcr_lane_t lanesOut [LANES_USED];
   logic [LANES_USED-1:0] lockVec;
   logic runMode;
   logic mfEdge;
   dcr_state_t state_reg, state_next;
   logic [1:0] syncCore_reg, syncCore_next;
   dcr_frame_t frame_reg, frame_next;
   logic [3:0] mfPos_reg, mfPos_next;

   // Lanes 0-1 from the first board's group, 2-3 from the second.
   assign lanesIn[0] = laneA0;
   assign lanesIn[1] = laneA1;
   assign lanesIn[2] = laneB0;
   assign lanesIn[3] = laneB1;

   // One aligner per used lane; the unused core lanes get none.
   for (genvar g = 0; g < LANES_USED; g++) begin : gLane
      dcr_lane_align #(.CGS_WORDS(CGS_WORDS)) uAlign (
         .clock(clock),
         .rst_n(rst_n),
         .laneIn(lanesIn[g]),
         .runMode(runMode),
         .laneOut(lanesOut[g]),
         .locked(lockVec[g])
      );
   end

   // Multiframe timing from the first board's SYSREF.
   dcr_mf_clock uMf (
      .clock(clock),
      .rst_n(rst_n),
      .sysrefPin(sysrefPin),
      .mfEdge(mfEdge)
   );

   function automatic logic convLocked(input logic [LANES_USED-1:0] v, input int c);
      return &v[c*CONV_LANES +: CONV_LANES];
   endfunction : convLocked

   // Link state: wait for lock, then release SYNC on a multiframe edge.
   always_comb begin
      state_next = state_reg;
      syncCore_next = syncCore_reg;
      case (state_reg)
         DCR_RESET: begin
            syncCore_next = 2'b00;
            state_next = DCR_WAIT_CGS;
         end
         DCR_WAIT_CGS: begin
            if (&lockVec) begin
               state_next = DCR_ARM;
            end
         end
         DCR_ARM: begin
            if (!(&lockVec)) begin
               state_next = DCR_WAIT_CGS;
            end else if (mfEdge) begin
               syncCore_next = {convLocked(lockVec, 1), convLocked(lockVec, 0)};
               state_next = DCR_RUN;
            end
         end
         DCR_RUN: begin
            // Lost lock requests resync, again only on a multiframe edge.
            if (!(&lockVec) && mfEdge) begin
               syncCore_next = 2'b00;
               state_next = DCR_WAIT_CGS;
            end
         end
         default: begin
            state_next = DCR_RESET;
         end
      endcase
   end

   // State registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= DCR_RESET;
         syncCore_reg <= 2'b00;
      end else begin
         state_reg <= state_next;
         syncCore_reg <= syncCore_next;
      end
   end

   // Split cores share one ANDed SYNC.
   // With a single core both bits move together, so the AND is harmless there too.
   // The split option changes nothing; both settings AND the two per-core requests.
   assign syncA_n = SPLIT_CORES ? &syncCore_reg : syncCore_reg[0] & syncCore_reg[1];
   assign syncB_n = syncA_n;
   assign runMode = (state_reg == DCR_RUN);
   assign linkUp = runMode;

   // Raw lane words, no sample reassembly.
   always_comb begin
      frame_next = '0;
      mfPos_next = mfPos_reg;
      if (runMode && lanesOut[0].valid) begin
         frame_next.valid = 1'b1;
         for (int i = 0; i < LANES_USED; i++) begin
            frame_next.data[i*32 +: 32] = lanesOut[i].data;
         end
         frame_next.mfStart = (mfPos_reg == 4'h0);
         mfPos_next = (mfPos_reg == 4'h7) ? 4'h0 : mfPos_reg + 4'h1;
      end else if (!runMode) begin
         mfPos_next = 4'h0;
      end
   end

   // Output registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_reg <= '0;
         mfPos_reg <= 4'h0;
      end else begin
         frame_reg <= frame_next;
         mfPos_reg <= mfPos_next;
      end
   end
   assign frameOut = frame_reg;

   sync_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(&lockVec) && state_reg != DCR_RUN |-> !syncA_n) else $error("SYNC released early");
   sync_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(syncA_n) |-> $past(mfEdge)) else $error("SYNC off multiframe edge");
   sync_and_a: assert property (@(posedge clock) disable iff (!rst_n)
      syncA_n == syncB_n) else $error("SYNC outputs differ");
   lane_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
      frameOut.data[255:128] == 128'h0) else $error("Unused lanes not zero");
   frame_run_a: assert property (@(posedge clock) disable iff (!rst_n)
      frameOut.valid |-> $past(runMode)) else $error("Frame while link down");
   word_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
      runMode && lanesOut[0].valid |=> frameOut.data[31:0] == $past(lanesOut[0].data))
      else $error("Lane word not forwarded");
   lock_inv_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(lockVec[0]) |-> $past(lanesIn[0].data) == ~{4{`DCR_KCHAR}})
      else $error("Lock without inverted comma");
   mf_mark_a: assert property (@(posedge clock) disable iff (!rst_n)
      frameOut.mfStart |-> frameOut.valid && !$past(frameOut.mfStart))
      else $error("Marker misplaced");
endmodule : dcr_receiver
`default_nettype wire

// ==== inc/dcr_regs.svh ====
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH
// Link shape and timing counts.
`define DCR_LANES_CORE 8
`define DCR_LANES_USED 4
`define DCR_LANES_PER_CONV 2
`define DCR_OCTETS_PER_FRAME 2
`define DCR_FRAMES_PER_MF 16
`define DCR_WORD_BITS 32
`define DCR_LANE_CLK_KHZ 147456
`define DCR_CLK_KHZ 25000
`define DCR_CGS_WORDS 4
`define DCR_KCHAR 8'hBC
`endif

// ==== inc/dcr_pkg.sv ====
`default_nettype none
package dcr_pkg;
   // One decoded lane word with its control-character flags.
   typedef struct packed {
      logic [31:0] data;
      logic [3:0] isK;
      logic valid;
   } dcr_lane_t;
   // Raw frame bundle handed to the capture block.
   typedef struct packed {
      logic [255:0] data;
      logic valid;
      logic mfStart;
   } dcr_frame_t;
   typedef enum {DCR_RESET, DCR_WAIT_CGS, DCR_ARM, DCR_RUN} dcr_state_t;
endpackage : dcr_pkg
`default_nettype wire

// ==== design/dcr_lane_align.sv ====
`include "dcr_regs.svh"
`default_nettype none
// Per-lane polarity fix, descrambling and code-group lock detection.
module dcr_lane_align #(
   parameter int CGS_WORDS = `DCR_CGS_WORDS
) (
   input wire logic clock,
   input wire logic rst_n,
   input var dcr_pkg::dcr_lane_t laneIn,
   input wire logic runMode,
   output var dcr_pkg::dcr_lane_t laneOut,
   output logic locked
);
   import dcr_pkg::*;
   logic [31:0] fixedData;
   logic [14:0] scr_reg, scr_next;
   logic [31:0] descr;
   logic [3:0] cnt_reg, cnt_next;
   logic locked_reg, locked_next;
   dcr_lane_t out_reg, out_next;

   // Self-synchronous descrambler, 1 + x^14 + x^15, bytes MSB first.
   function automatic logic [46:0] descramble(input logic [14:0] s, input logic [31:0] d);
      logic [14:0] st;
      logic [31:0] o;
      st = s;
      o = 32'h0;
      for (int i = 31; i >= 0; i--) begin
         o[i] = d[i] ^ st[13] ^ st[14];
         st = {st[13:0], d[i]};
      end
      return {st, o};
   endfunction : descramble

   // Lane inversion fix.
   // Board swaps the conductors, so every decoded bit arrives inverted.
   assign fixedData = ~laneIn.data;

   // Lock counter, descrambler state and the output word.
   always_comb begin
      scr_next = scr_reg;
      descr = fixedData;
      cnt_next = cnt_reg;
      locked_next = locked_reg;
      out_next = out_reg;
      out_next.valid = 1'b0;
      if (laneIn.valid) begin
         if (fixedData == {4{`DCR_KCHAR}} && laneIn.isK == 4'hF) begin
            if (!locked_reg && cnt_reg != 4'(CGS_WORDS - 1)) begin
               cnt_next = cnt_reg + 4'h1;
            end else begin
               locked_next = 1'b1;
            end
         end else if (!locked_reg) begin
            cnt_next = 4'h0;
         end
         // Descrambling enabled.
         // Control words bypass the descrambler, since the last commas still in flight
         // would otherwise seed it with garbage and spoil the first data word.
         if (runMode && laneIn.isK == 4'h0) begin
            {scr_next, descr} = descramble(scr_reg, fixedData);
         end
         out_next.data = descr;
         out_next.isK = laneIn.isK;
         out_next.valid = 1'b1;
      end
   end

   // State registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scr_reg <= 15'h0;
         cnt_reg <= 4'h0;
         locked_reg <= 1'b0;
         out_reg <= '0;
      end else begin
         scr_reg <= scr_next;
         cnt_reg <= cnt_next;
         locked_reg <= locked_next;
         out_reg <= out_next;
      end
   end

   assign laneOut = out_reg;
   assign locked = locked_reg;
endmodule : dcr_lane_align
`default_nettype wire

// ==== design/dcr_mf_clock.sv ====
`include "dcr_regs.svh"
`default_nettype none
// Local multiframe clock, phase set by the first synchronised SYSREF edge.
module dcr_mf_clock #(
   parameter int FRAMES = `DCR_FRAMES_PER_MF,
   parameter int OCTETS = `DCR_OCTETS_PER_FRAME
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sysrefPin,
   output logic mfEdge
);
   localparam int WORDS = FRAMES * OCTETS / 4;
   logic [1:0] sync_reg;
   logic sysOld_reg;
   logic [3:0] cnt_reg, cnt_next;
   logic aligned_reg, aligned_next;
   logic sysRise;

   // Two flops on the pin; only the second is used further.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= 2'b00;
         sysOld_reg <= 1'b0;
      end else begin
         sync_reg <= {sync_reg[0], sysrefPin};
         sysOld_reg <= sync_reg[1];
      end
   end
   assign sysRise = sync_reg[1] & ~sysOld_reg;

   // Shared SYSREF alignment.
   // Later SYSREF edges are ignored so the multiframe phase stays put.
   always_comb begin
      cnt_next = (cnt_reg == 4'(WORDS - 1)) ? 4'h0 : cnt_reg + 4'h1;
      aligned_next = aligned_reg;
      if (sysRise && !aligned_reg) begin
         cnt_next = 4'h0;
         aligned_next = 1'b1;
      end
   end

   // Counter registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         aligned_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         aligned_reg <= aligned_next;
      end
   end

   assign mfEdge = aligned_reg && (cnt_reg == 4'h0);
endmodule : dcr_mf_clock
`default_nettype wire

// ==== bench/dcr_conv_model.sv ====
`default_nettype none
// Two converters, each driving two lanes whose conductors arrive swapped.
module dcr_conv_model (
   input wire logic clock,
   input wire logic syncA_n,
   input wire logic syncB_n,
   input wire logic enA,
   input wire logic enB,
   input wire logic [31:0] payA1,
   output var dcr_pkg::dcr_lane_t laneA0,
   output var dcr_pkg::dcr_lane_t laneA1,
   output var dcr_pkg::dcr_lane_t laneB0,
   output var dcr_pkg::dcr_lane_t laneB1
);
   timeunit 1ns;
   timeprecision 1ps;
   import dcr_pkg::*;
   logic [31:0] noise_reg = 32'h0;

   // A silent converter shows a changing pattern, so stale words never pass for commas.
   function automatic dcr_lane_t word(input logic en, input logic sync_n,
                                      input logic [31:0] pay, input logic [31:0] junk);
      if (!en) begin
         return '{data: junk, isK: 4'h0, valid: 1'b0};
      end
      if (sync_n) begin
         return '{data: ~pay, isK: 4'h0, valid: 1'b1};
      end
      return '{data: ~32'hBCBCBCBC, isK: 4'hF, valid: 1'b1};
   endfunction : word

   // Lanes start quiet at time zero.
   initial begin
      laneA0 = '0;
      laneA1 = '0;
      laneB0 = '0;
      laneB1 = '0;
   end

   // Words change just after the edge, the same way the bench drives its inputs.
   always @(posedge clock) begin
      noise_reg <= noise_reg + 32'h9E37;
      laneA0 <= #1 word(enA, syncA_n, 32'h0, noise_reg);
      laneA1 <= #1 word(enA, syncA_n, payA1, noise_reg);
      laneB0 <= #1 word(enB, syncB_n, 32'h0, ~noise_reg);
      laneB1 <= #1 word(enB, syncB_n, 32'h0, ~noise_reg);
   end
endmodule : dcr_conv_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dcr_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sysrefPin = 1'b0;
   logic enA = 1'b0;
   logic enB = 1'b0;
   logic [31:0] payA1 = 32'h0;
   dcr_lane_t laneA0, laneA1, laneB0, laneB1;
   logic syncA_n, syncB_n, linkUp;
   dcr_frame_t frameOut;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int riseAt [2];

   dcr_receiver i_dut (.clock(clock), .rst_n(rst_n), .sysrefPin(sysrefPin),
      .laneA0(laneA0), .laneA1(laneA1), .laneB0(laneB0), .laneB1(laneB1),
      .syncA_n(syncA_n), .syncB_n(syncB_n), .frameOut(frameOut), .linkUp(linkUp));
   dcr_conv_model i_conv (.clock(clock), .syncA_n(syncA_n), .syncB_n(syncB_n),
      .enA(enA), .enB(enB), .payA1(payA1), .laneA0(laneA0), .laneA1(laneA1),
      .laneB0(laneB0), .laneB1(laneB1));

   // Free-running 25 MHz clock.
   initial begin
      forever #20 clock = ~clock;
   end

   // The whole run takes roughly a hundred cycles, so this ceiling only trips on a hang.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // Reset for four cycles with both converters silent.
   task automatic reset_dut();
      rst_n = 1'b0;
      enA = 1'b0;
      enB = 1'b0;
      sysrefPin = 1'b0;
      tick(4);
      check({syncA_n, syncB_n, linkUp, frameOut.valid}, 4'h0);
      rst_n = 1'b1;
   endtask : reset_dut

   // Lock, then measure from the SYSREF rise to the release of the request.
   // A late second SYSREF edge must not move the multiframe phase.
   task automatic lock_run(input int idx, input int bDelay);
      int n;
      enA = 1'b1;
      enB = (bDelay == 0);
      tick(8);
      sysrefPin = 1'b1;
      for (n = 0; n < bDelay; n++) begin
         sysrefPin = (n != 10);
         tick(1);
         check({syncA_n, syncB_n, frameOut.valid}, 3'h0);
      end
      enB = 1'b1;
      while (syncA_n !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      riseAt[idx] = n;
      check({syncA_n, syncB_n}, 2'h3);
      tick(2);
      check(linkUp, 1'b1);
   endtask : lock_run

   // Inverted all-zero words descramble to zero; idle lanes stay zero.
   task automatic stream_zero();
      int v = 0;
      int m = 0;
      repeat (24) begin
         tick(1);
         if (frameOut.valid === 1'b1) begin
            v++;
            m += int'(frameOut.mfStart);
            check(frameOut.data, 256'h0);
         end
      end
      check(v, 24);
      check(m, 3);
   endtask : stream_zero

   // One marked word on the second lane must surface in its own slot only.
   task automatic lane_map();
      int hits = 0;
      payA1 = 32'h00010000;
      tick(1);
      payA1 = 32'h0;
      repeat (8) begin
         tick(1);
         check({frameOut.data[255:64], frameOut.data[31:0]}, 256'h0);
         hits += int'(frameOut.data[63:32] != 32'h0);
      end
      check(hits > 0, 1'b1);
   endtask : lane_map

   // Main sequence.
   initial begin
      reset_dut();
      lock_run(0, 0);
      stream_zero();
      lane_map();
      reset_dut();
      lock_run(1, 21);
      check(riseAt[1] % 8, riseAt[0] % 8);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
